//--- common/isb_pkg.sv
/*
 * isb_pkg: constants and types for the two-wire serial port block.
 * assumes: included before core/isb_port.sv; no other dependencies.
 */
package isb_pkg;

  // ****************************************
  // mode select encodings
  // ****************************************
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_SLV7_SP = 4'hE;
  localparam logic [3:0] MODE_SLV10_SP = 4'hF;

  // ****************************************
  // second control register low bits
  // ****************************************
  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_RECV = 3;
  localparam int CTL_ACK = 4;
  localparam int CTL_W = 5;

  // ****************************************
  // framing and sizes
  // ****************************************
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam int BRG_W = 7;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] SLV_ACK_PHASE = 4'h9;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;

  // master operation being framed
  localparam logic [1:0] OP_TX = 2'h1;
  localparam logic [1:0] OP_RX = 2'h2;
  localparam logic [1:0] OP_ACK = 2'h3;

  typedef enum logic [7:0] {
    ISB_IDLE = 8'h01,
    ISB_ST_WAIT = 8'h02,
    ISB_ST_HOLD = 8'h04,
    ISB_BIT_LOW = 8'h08,
    ISB_BIT_HIGH = 8'h10,
    ISB_SP_LOW = 8'h20,
    ISB_SP_HIGH = 8'h40,
    ISB_SP_DONE = 8'h80
  } isb_state_t;

endpackage

//--- core/isb_port.sv
/*
 * isb_port: two-wire serial port, master framing with start generation,
 * down-counting baud generator, and slave address match with general call.
 * isb_fifo: receive buffer between the line logic and software reads.
 * assumes: one 25 MHz clock; pins are open drain and resolved outside;
 * software strobes are one-cycle pulses on the same clock.
 */
// Operation
// - all-zero address byte with write direction is the general call
// - with general call enabled, compare against own and general call address
// - on general call match load buffer at bit eight, flag at ninth fall
// - general call in 10-bit mode leaves need_addr_update clear
// - begin_detected and end_found clear on reset and port disable
// - master flags interrupt after start, stop, byte, acknowledge
// - no queueing: early data buffer write is dropped, write_collision set
// - master makes all clock pulses and start and stop conditions
// - transmit sends eight bits, captures acknowledge into ack_status_bit
// - receive takes eight bits, acknowledge then driven by software request
// - generator reload is low seven bits of address register
// - generator starts on buffer write, stops after operation, clock holds
// - loaded generator counts to zero then halts until reloaded
// - generator decrements twice per instruction cycle
// - generator reload waits while clock line is held low by others
// - start: both high, count, drive data low, set begin_detected
// - count again, clear start_request, suspend, keep data low
// - both low at start or clock falls early: collision, abort, idle
// - buffer write during start sets write_collision, no write
// - low five control bits ignore writes until start completes
`timescale 1ns/10ps

module isb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock, // system clock
  input wire logic clr, // synchronous clear, active high
  input wire logic in_valid, // push request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // pushed word
  output logic out_valid, // word available
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  assign in_ready = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

module isb_port (
  input wire logic clock, // 25 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic port_enable, // module enable
  input wire logic [3:0] mode_select_field, // mode encoding
  input wire logic general_call_enable, // accept general call
  input wire logic [7:0] address_register, // own address / reload value
  input wire logic addr_wr, // address register written, pulse
  input wire logic ctl_wr, // write of second control register, pulse
  input wire logic [isb_pkg::CTL_W-1:0] ctl_wdata, // low control bits
  input wire logic ack_data, // acknowledge level to send, 0 = ack
  input wire logic buf_wr, // data buffer write, pulse
  input wire logic [7:0] buf_wdata, // data buffer write value
  input wire logic buf_rd, // data buffer read, pulse
  output logic [7:0] buf_rdata, // data buffer read value
  input wire logic irq_clr, // clear port_interrupt_flag, pulse
  input wire logic write_collision_clr, // clear write_collision, pulse
  input wire logic bcl_clr, // clear bus_collision_flag, pulse
  output logic start_request, // start in progress
  output logic stop_request, // stop in progress
  output logic recv_request, // receive in progress
  output logic ack_request, // acknowledge in progress
  output logic buffer_full, // buffer holds a byte
  output logic write_collision, // sticky dropped write
  output logic bus_collision_flag, // sticky collision
  output logic port_interrupt_flag, // sticky event flag
  output logic ack_status_bit, // last acknowledge seen, 1 = none
  output logic begin_detected, // start seen on bus
  output logic end_found, // stop seen on bus
  output logic need_addr_update, // 10-bit address register update due
  input wire logic scl_in, // clock pin level
  output logic scl_out, // clock pin drive value
  output logic scl_oe, // clock pin pulled low when high
  input wire logic sda_in, // data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe // data pin pulled low when high
);
  import isb_pkg::*;

  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
    end
  end

  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_det = scl_s && scl_p && !sda_s && sda_p;
  assign stop_det = scl_s && scl_p && sda_s && !sda_p;

  // disable clears everything like reset except the pin synchronisers
  logic clr;
  logic is_master, ten_bit, slave_en;
  assign clr = !rst_n || !port_enable;
  assign is_master = (mode_select_field == MODE_MASTER);
  assign ten_bit = (mode_select_field == MODE_SLV10) || (mode_select_field == MODE_SLV10_SP);
  assign slave_en = !is_master;

  // ****************************************
  // receive buffer
  // ****************************************
  logic push, fifo_ready, fifo_valid;
  logic [7:0] push_data, fifo_head;

  isb_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .clr(clr),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(buf_rd),
    .out_data(fifo_head)
  );
  assign buf_rdata = fifo_head;

  // ****************************************
  // master sequencer and baud generator
  // ****************************************
  isb_state_t state, next_state;
  logic [1:0] ph, next_ph;
  logic [BRG_W-1:0] baud_rate_generator, next_brg, reload;
  logic [3:0] bitn, next_bitn;
  logic [1:0] op, next_op;
  logic [7:0] txsr, next_txsr, rxsr, next_rxsr;
  logic scl_low, next_scl_low, sda_low, next_sda_low;
  logic next_sen, next_pen, next_rcen, next_acken;
  logic txfull, next_txfull, next_ack_status_bit;
  logic tick, done, busy, last;
  logic m_irq, m_bcl, m_write_collision, m_begin, m_push;

  assign reload = address_register[BRG_W-1:0];
  assign tick = ph[0];
  assign done = (baud_rate_generator == '0);
  assign busy = (state != ISB_IDLE) || start_request || stop_request || recv_request
    || ack_request;

  always_comb begin
    next_state = state;
    next_ph = ph + 2'h1;
    next_brg = (tick && !done) ? baud_rate_generator - 7'h01 : baud_rate_generator;
    next_bitn = bitn;
    next_op = op;
    next_txsr = txsr;
    next_rxsr = rxsr;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_sen = start_request;
    next_pen = stop_request;
    next_rcen = recv_request;
    next_acken = ack_request;
    next_txfull = txfull;
    next_ack_status_bit = ack_status_bit;
    m_irq = 1'b0;
    m_bcl = 1'b0;
    m_write_collision = 1'b0;
    m_begin = 1'b0;
    m_push = 1'b0;
    last = (op == OP_RX) ? (bitn == LAST_DATA_BIT) : (bitn == ACK_BIT);
    // requests are dropped while any operation runs
    if (is_master && ctl_wr && !busy) begin
      next_sen = ctl_wdata[CTL_START];
      next_pen = ctl_wdata[CTL_STOP];
      next_rcen = ctl_wdata[CTL_RECV];
      next_acken = ctl_wdata[CTL_ACK];
    end
    if (is_master && buf_wr) begin
      if (busy) begin
        m_write_collision = 1'b1;
      end else begin
        next_txsr = buf_wdata;
        next_txfull = 1'b1;
        next_op = OP_TX;
        next_bitn = 4'h0;
        next_scl_low = 1'b1;
        next_brg = reload;
        next_state = ISB_BIT_LOW;
      end
    end
    unique case (state)
      ISB_IDLE: begin
        if (start_request) begin
          if (scl_s && sda_s) begin
            next_brg = reload;
            next_state = ISB_ST_WAIT;
          end else if (!scl_s && !sda_s) begin
            m_bcl = 1'b1;
            next_sen = 1'b0;
          end
        end else if (stop_request) begin
          next_scl_low = 1'b1;
          next_sda_low = 1'b1;
          next_brg = reload;
          next_state = ISB_SP_LOW;
        end else if (recv_request && fifo_ready) begin
          next_op = OP_RX;
          next_bitn = 4'h0;
          next_scl_low = 1'b1;
          next_sda_low = 1'b0;
          next_brg = reload;
          next_state = ISB_BIT_LOW;
        end else if (ack_request) begin
          next_op = OP_ACK;
          next_bitn = ACK_BIT;
          next_scl_low = 1'b1;
          next_brg = reload;
          next_state = ISB_BIT_LOW;
        end
      end
      ISB_ST_WAIT: begin
        if (!scl_s) begin
          m_bcl = 1'b1;
          next_sen = 1'b0;
          next_state = ISB_IDLE;
        end else if (done) begin
          if (sda_s) begin
            next_sda_low = 1'b1;
            m_begin = 1'b1;
            next_brg = reload;
            next_state = ISB_ST_HOLD;
          end else begin
            m_bcl = 1'b1;
            next_sen = 1'b0;
            next_state = ISB_IDLE;
          end
        end
      end
      ISB_ST_HOLD: begin
        if (done) begin
          next_sen = 1'b0;
          m_irq = 1'b1;
          next_state = ISB_IDLE;
        end
      end
      ISB_BIT_LOW: begin
        // data changes only while the clock is held low
        unique case (op)
          OP_TX: next_sda_low = (bitn == ACK_BIT) ? 1'b0 : !txsr[7];
          OP_ACK: next_sda_low = !ack_data;
          default: next_sda_low = 1'b0;
        endcase
        if (done) begin
          next_scl_low = 1'b0;
          next_brg = reload;
          next_state = ISB_BIT_HIGH;
        end
      end
      ISB_BIT_HIGH: begin
        if (!scl_s) begin
          next_brg = reload;
        end else if (done) begin
          if (op == OP_TX && bitn == ACK_BIT) begin
            next_ack_status_bit = sda_s;
          end
          if (op == OP_TX && bitn == LAST_DATA_BIT) begin
            next_txfull = 1'b0;
          end
          if (op == OP_TX) begin
            next_txsr = {txsr[6:0], 1'b0};
          end
          if (op == OP_RX) begin
            next_rxsr = {rxsr[6:0], sda_s};
          end
          next_scl_low = 1'b1;
          if (last) begin
            // generator stays suspended with the clock held low
            m_irq = 1'b1;
            m_push = (op == OP_RX);
            next_rcen = 1'b0;
            next_acken = 1'b0;
            next_sda_low = 1'b0;
            next_state = ISB_IDLE;
          end else begin
            next_bitn = bitn + 4'h1;
            next_brg = reload;
            next_state = ISB_BIT_LOW;
          end
        end
      end
      ISB_SP_LOW: begin
        if (done) begin
          next_scl_low = 1'b0;
          next_brg = reload;
          next_state = ISB_SP_HIGH;
        end
      end
      ISB_SP_HIGH: begin
        if (!scl_s) begin
          next_brg = reload;
        end else if (done) begin
          next_sda_low = 1'b0;
          next_brg = reload;
          next_state = ISB_SP_DONE;
        end
      end
      ISB_SP_DONE: begin
        if (done) begin
          next_pen = 1'b0;
          m_irq = 1'b1;
          next_state = ISB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (clr || !is_master) begin
      state <= ISB_IDLE;
      ph <= 2'h0;
      baud_rate_generator <= '0;
      bitn <= 4'h0;
      op <= OP_TX;
      txsr <= 8'h00;
      rxsr <= 8'h00;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      recv_request <= 1'b0;
      ack_request <= 1'b0;
      txfull <= 1'b0;
      ack_status_bit <= 1'b0;
    end else begin
      state <= next_state;
      ph <= next_ph;
      baud_rate_generator <= next_brg;
      bitn <= next_bitn;
      op <= next_op;
      txsr <= next_txsr;
      rxsr <= next_rxsr;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      start_request <= next_sen;
      stop_request <= next_pen;
      recv_request <= next_rcen;
      ack_request <= next_acken;
      txfull <= next_txfull;
      ack_status_bit <= next_ack_status_bit;
    end
  end

  // ****************************************
  // slave address match and bus status
  // ****************************************
  logic [3:0] sbits, next_sbits;
  logic [7:0] ssr, next_ssr;
  logic saddr, next_saddr, ssel, next_ssel, sack, next_sack;
  logic next_begin, next_end, next_ua;
  logic s_irq, s_push, gc_hit, own_hit;

  always_comb begin
    next_sbits = sbits;
    next_ssr = ssr;
    next_saddr = saddr;
    next_ssel = ssel;
    next_sack = sack;
    next_ua = need_addr_update && !addr_wr;
    s_irq = 1'b0;
    s_push = 1'b0;
    gc_hit = general_call_enable && (ssr == GEN_CALL_ADDR);
    own_hit = (ssr[7:1] == address_register[7:1]);
    // a master start and a stop seen in the same cycle set both begin_detected and end_found
    next_begin = start_det || m_begin || (begin_detected && !stop_det);
    next_end = stop_det || (end_found && !start_det && !m_begin);
    if (slave_en) begin
      if (start_det) begin
        next_sbits = 4'h0;
        next_saddr = 1'b1;
        next_ssel = 1'b0;
        next_sack = 1'b0;
      end else if (stop_det) begin
        next_saddr = 1'b0;
        next_ssel = 1'b0;
        next_sack = 1'b0;
      end else if (scl_rise && (saddr || ssel) && sbits < ACK_BIT) begin
        next_ssr = {ssr[6:0], sda_s};
        next_sbits = sbits + 4'h1;
      end else if (scl_fall && sbits == ACK_BIT) begin
        next_sbits = SLV_ACK_PHASE;
        if (saddr) begin
          next_saddr = 1'b0;
          if ((gc_hit || own_hit) && fifo_ready) begin
            s_push = 1'b1;
            next_sack = 1'b1;
            next_ssel = 1'b1;
            next_ua = ten_bit && !gc_hit;
          end
        end else if (ssel && fifo_ready) begin
          s_push = 1'b1;
          next_sack = 1'b1;
        end
      end else if (scl_fall && sbits == SLV_ACK_PHASE) begin
        s_irq = sack;
        next_sack = 1'b0;
        next_sbits = 4'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      sbits <= 4'h0;
      ssr <= 8'h00;
      saddr <= 1'b0;
      ssel <= 1'b0;
      sack <= 1'b0;
      begin_detected <= 1'b0;
      end_found <= 1'b0;
      need_addr_update <= 1'b0;
    end else begin
      sbits <= next_sbits;
      ssr <= next_ssr;
      saddr <= next_saddr;
      ssel <= next_ssel;
      sack <= next_sack;
      begin_detected <= next_begin;
      end_found <= next_end;
      need_addr_update <= next_ua;
    end
  end

  // ****************************************
  // sticky flags, set wins over clear
  // ****************************************
  always_ff @(posedge clock) begin
    if (clr) begin
      port_interrupt_flag <= 1'b0;
      write_collision <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else begin
      port_interrupt_flag <= m_irq || s_irq || (port_interrupt_flag && !irq_clr);
      write_collision <= m_write_collision || (write_collision && !write_collision_clr);
      bus_collision_flag <= m_bcl || (bus_collision_flag && !bcl_clr);
    end
  end

  assign push = m_push || s_push;
  assign push_data = m_push ? next_rxsr : ssr;
  assign buffer_full = txfull || fifo_valid;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low;
  assign sda_oe = sda_low || sack;

endmodule

//--- tb/isb_port_props.sv
/*
 * isb_port_props: concurrent checks on the ports of isb_port.
 * assumes: one clock domain, synchronous active-low reset; bound below.
 */
`timescale 1ns/10ps
module isb_port_props import isb_pkg::*; (
  input wire logic clock, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic port_enable, // module enable
  input wire logic [3:0] mode_select_field, // mode encoding
  input wire logic buf_wr, // data write pulse
  input wire logic ctl_wr, // control write pulse
  input wire logic start_request, // start running
  input wire logic stop_request, // stop running
  input wire logic recv_request, // receive running
  input wire logic ack_request, // ack running
  input wire logic buffer_full, // buffer holds byte
  input wire logic write_collision, // dropped write
  input wire logic bus_collision_flag, // collision
  input wire logic port_interrupt_flag, // event flag
  input wire logic begin_detected, // start seen
  input wire logic end_found, // stop seen
  input wire logic scl_oe, // clock pulled low
  input wire logic sda_oe // data pulled low
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_write_collision_busy: assert property (
    port_enable && buf_wr && start_request |=> write_collision)
    else $error("data write during start not flagged");
  chk_ctl_ignored: assert property (
    port_enable && ctl_wr && start_request |=> !stop_request && !recv_request && !ack_request)
    else $error("control write taken during start");
  chk_off_clears: assert property (
    !port_enable |=> !begin_detected && !end_found && !port_interrupt_flag && !bus_collision_flag)
    else $error("disable left status set");
  chk_start_done: assert property (
    $fell(start_request) && $past(port_enable) && $past(rst_n) && !bus_collision_flag
      |-> port_interrupt_flag && sda_oe)
    else $error("start end without flag or data hold");
  chk_start_begin: assert property (
    start_request && $rose(sda_oe) |-> ##[0:4] begin_detected)
    else $error("start driven without begin status");
  chk_bcl_abort: assert property (
    $rose(bus_collision_flag) |-> !start_request && !sda_oe)
    else $error("collision did not abort start");
  chk_tx_clock: assert property (
    $past(buf_wr) && $rose(buffer_full) && mode_select_field == MODE_MASTER |-> scl_oe)
    else $error("transmit did not start clocking");
  chk_slave_ack: assert property (
    $rose(buffer_full) && mode_select_field != MODE_MASTER |-> ##[0:3] sda_oe)
    else $error("matched byte not acknowledged");
  chk_slave_irq: assert property (
    $rose(port_interrupt_flag) && mode_select_field != MODE_MASTER |-> buffer_full)
    else $error("slave flag without buffered byte");
endmodule

bind isb_port isb_port_props u_props (.clock(clock), .rst_n(rst_n), .port_enable(port_enable),
  .mode_select_field(mode_select_field), .buf_wr(buf_wr), .ctl_wr(ctl_wr),
  .start_request(start_request), .stop_request(stop_request), .recv_request(recv_request),
  .ack_request(ack_request), .buffer_full(buffer_full), .write_collision(write_collision),
  .bus_collision_flag(bus_collision_flag), .port_interrupt_flag(port_interrupt_flag),
  .begin_detected(begin_detected), .end_found(end_found), .scl_oe(scl_oe), .sda_oe(sda_oe));

//--- tb/isb_bus_model.sv
/*
 * isb_bus_model: slave on the two-wire bus; acks bytes, stretches clock.
 * assumes: lines are pulled up and resolved by the bench.
 */
`timescale 1ns/10ps
module isb_bus_model (
  input wire logic clock, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic scl, // resolved clock line
  input wire logic sda, // resolved data line
  input wire logic ack_en, // acknowledge each byte
  input wire logic stretch, // hold clock low after each fall
  input wire logic tb_scl_low, // bench pulls clock low
  input wire logic tb_sda_low, // bench pulls data low
  output logic scl_oe, // model pulls clock low
  output logic sda_oe, // model pulls data low
  output logic [7:0] rx_byte // last byte seen on the bus
);
  // ****************************************
  // bit counter and line drive
  // ****************************************
  logic scl_d, sda_d, ack_drv;
  logic [3:0] nbit;
  logic [4:0] hold;
  always_ff @(posedge clock) begin
    scl_d <= scl;
    sda_d <= sda;
    if (!rst_n) begin
      nbit <= 4'h0;
      ack_drv <= 1'b0;
      hold <= 5'h00;
    end else begin
      if (hold != 5'h00) hold <= hold - 5'h01;
      if (scl_d && scl && sda_d && !sda) nbit <= 4'h0;
      else if (!scl_d && scl) begin
        nbit <= nbit + 4'h1;
        if (nbit < 4'h8) rx_byte <= {rx_byte[6:0], sda};
      end else if (scl_d && !scl) begin
        // slow slave: clock held low well past the master's low phase
        if (stretch) hold <= 5'h14;
        if (nbit == 4'h8) ack_drv <= ack_en;
        if (nbit == 4'h9) begin
          ack_drv <= 1'b0;
          nbit <= 4'h0;
        end
      end
    end
  end
  assign scl_oe = tb_scl_low | (hold != 5'h00);
  assign sda_oe = tb_sda_low | ack_drv;
endmodule

//--- tb/isb_port_tb.sv
/*
 * isb_port_tb: directed bench for isb_port, master and slave paths.
 * assumes: isb_pkg, isb_port, isb_bus_model and the bound checker compiled.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module isb_port_tb;
  import isb_pkg::*;
  logic clock, rst_n, port_enable, general_call_enable, addr_wr, ctl_wr, ack_data, buf_wr;
  logic buf_rd, irq_clr, write_collision_clr, bcl_clr, start_request, stop_request, recv_request;
  logic ack_request, buffer_full, write_collision, bus_collision_flag, port_interrupt_flag;
  logic ack_status_bit, begin_detected, end_found, need_addr_update, scl_out, scl_oe;
  logic sda_out, sda_oe, m_scl_oe, m_sda_oe, ack_en, stretch, tb_scl_low, tb_sda_low;
  logic [3:0] mode_select_field;
  logic [4:0] ctl_wdata;
  logic [7:0] address_register, buf_wdata, buf_rdata, rx_byte;
  int n_errors, n_checks, k;
  // pull-ups on both lines
  wire scl = !(scl_oe | m_scl_oe);
  wire sda = !(sda_oe | m_sda_oe);

  isb_port dut (.clock, .rst_n, .port_enable, .mode_select_field, .general_call_enable,
    .address_register, .addr_wr, .ctl_wr, .ctl_wdata, .ack_data, .buf_wr, .buf_wdata,
    .buf_rd, .buf_rdata, .irq_clr, .write_collision_clr, .bcl_clr, .start_request, .stop_request,
    .recv_request, .ack_request, .buffer_full, .write_collision, .bus_collision_flag,
    .port_interrupt_flag, .ack_status_bit, .begin_detected, .end_found, .need_addr_update,
    .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
  isb_bus_model u_slave (.clock, .rst_n, .scl, .sda, .ack_en, .stretch, .tb_scl_low,
    .tb_sda_low, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte);

  // ****************************************
  // tasks
  // ****************************************
  task tick(input int n); repeat (n) @(posedge clock); endtask
  task pulse_ctl(input logic [4:0] v);
    ctl_wdata <= v; ctl_wr <= 1'b1; tick(1); ctl_wr <= 1'b0;
  endtask
  task wr_buf(input logic [7:0] v);
    buf_wdata <= v; buf_wr <= 1'b1; tick(1); buf_wr <= 1'b0;
  endtask
  task rd_buf; buf_rd <= 1'b1; tick(1); buf_rd <= 1'b0; endtask
  task clr_flags;
    irq_clr <= 1'b1; write_collision_clr <= 1'b1; bcl_clr <= 1'b1; tick(1);
    irq_clr <= 1'b0; write_collision_clr <= 1'b0; bcl_clr <= 1'b0;
  endtask
  // bounded wait on the event flag (sel 0) or the collision flag
  task wait_flag(input int sel, input int lim);
    k = 0;
    while (((sel == 0) ? port_interrupt_flag : bus_collision_flag) !== 1'b1 && k < lim) begin
      tick(1); k++;
    end
    `CHK(k < lim, 1'b1)
  endtask
  // bench as a foreign master, one bit with slow phases
  task bus_bit(input logic b);
    tb_sda_low <= !b; tick(8); tb_scl_low <= 1'b0; tick(8); tb_scl_low <= 1'b1; tick(8);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = !clock;
  end
  initial begin
    tick(20000);
    n_errors++;
    test_done;
  end

  initial begin
    {rst_n, general_call_enable, addr_wr, ctl_wr, ack_data, buf_wr, buf_rd} = '0;
    {irq_clr, write_collision_clr, bcl_clr, stretch, tb_scl_low, tb_sda_low} = '0;
    {ctl_wdata, buf_wdata} = '0;
    port_enable = 1'b1;
    ack_en = 1'b1;
    mode_select_field = MODE_MASTER;
    address_register = 8'h83; // bit 7 must not reach the generator
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    `CHK(begin_detected, 1'b0)
    `CHK(end_found, 1'b0)
    pulse_ctl(5'h01);
    wr_buf(8'hA5);
    pulse_ctl(5'h04);
    tick(1);
    `CHK(write_collision, 1'b1)
    wait_flag(0, 60);
    `CHK(start_request, 1'b0)
    `CHK(sda_oe, 1'b1)
    `CHK(begin_detected, 1'b1)
    `CHK(stop_request, 1'b0)
    clr_flags;
    stretch <= 1'b1;
    wr_buf(8'hA4);
    wait_flag(0, 900);
    `CHK(rx_byte, 8'hA4)
    `CHK(ack_status_bit, 1'b0)
    `CHK(buffer_full, 1'b0)
    clr_flags;
    stretch <= 1'b0;
    ack_en <= 1'b0;
    wr_buf(8'h5B);
    wait_flag(0, 600);
    `CHK(rx_byte, 8'h5B)
    `CHK(ack_status_bit, 1'b1)
    clr_flags;
    pulse_ctl(5'h08);
    wait_flag(0, 600);
    `CHK(recv_request, 1'b0)
    `CHK(buffer_full, 1'b1)
    `CHK(buf_rdata, 8'hFF)
    rd_buf;
    clr_flags;
    pulse_ctl(5'h10);
    wait_flag(0, 600);
    `CHK(ack_request, 1'b0)
    clr_flags;
    pulse_ctl(5'h04);
    wait_flag(0, 600);
    `CHK(stop_request, 1'b0)
    `CHK(end_found, 1'b1)
    `CHK(begin_detected, 1'b0)
    clr_flags;
    tb_sda_low <= 1'b1;
    tb_scl_low <= 1'b1;
    tick(4);
    pulse_ctl(5'h01);
    wait_flag(1, 40);
    `CHK(start_request, 1'b0)
    tb_scl_low <= 1'b0;
    tick(4);
    tb_sda_low <= 1'b0;
    tick(4);
    port_enable <= 1'b0;
    tick(2);
    `CHK(bus_collision_flag, 1'b0)
    `CHK(end_found, 1'b0)
    port_enable <= 1'b1;
    // slave: 10-bit with general call on, then 7-bit with it off
    for (int i = 0; i < 2; i++) begin
      mode_select_field <= (i == 0) ? MODE_SLV10 : MODE_SLV7;
      general_call_enable <= (i == 0);
      address_register <= 8'h84;
      tick(4);
      tb_sda_low <= 1'b1;
      tick(8);
      tb_scl_low <= 1'b1;
      tick(8);
      for (int b = 0; b < 8; b++) bus_bit(1'b0);
      tb_sda_low <= 1'b0;
      tick(8);
      `CHK(sda, (i != 0))
      `CHK(buffer_full, (i == 0))
      tb_scl_low <= 1'b0;
      tick(8);
      tb_scl_low <= 1'b1;
      tick(8);
      `CHK(port_interrupt_flag, (i == 0))
      `CHK(need_addr_update, 1'b0)
      if (i == 0) `CHK(buf_rdata, 8'h00)
      rd_buf;
      tb_sda_low <= 1'b1;
      tick(8);
      tb_scl_low <= 1'b0;
      tick(8);
      tb_sda_low <= 1'b0;
      tick(8);
      clr_flags;
    end
    test_done;
  end
endmodule
